// >>> rtl/l2_cache_mode_pkg.sv
// package: register map, control fields, reset values and line states for the l2 mode control
package l2_cache_mode_pkg;

   // ----------------------------------------------------------------
   // register offsets (byte addresses on apb)
   // ----------------------------------------------------------------
   localparam logic [11:0] CTRL_OFFSET   = 12'h000;
   localparam logic [11:0] STATUS_OFFSET = 12'h004;

   // ----------------------------------------------------------------
   // control register layout, bit n of the big-endian map sits at 31-n
   // ----------------------------------------------------------------
   localparam int EN_BIT       = 31;
   localparam int RAM_TYPE_LSB = 23;
   localparam int DO_BIT       = 22;
   localparam int INV_BIT      = 21;
   localparam int CTL_BIT      = 20;
   localparam int WT_BIT       = 19;
   localparam int TS_BIT       = 18;
   localparam int OH_LSB       = 16;
   localparam int IO_BIT       = 10;

   localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
   // big-endian bits 0..23 are storage; dll counter and bit 31 read as zero here
   localparam logic [31:0] CTRL_WR_MASK = 32'hffff_ff00;

   localparam logic [1:0]  RAM_TYPE_PIPELINED = 2'b10;
   localparam logic [1:0]  OH_LEAST           = 2'b00;

   // ----------------------------------------------------------------
   // status register layout (read only)
   // ----------------------------------------------------------------
   localparam int ST_LOW_POWER_BIT = 0;
   localparam int ST_ANY_VALID_BIT = 1;
   localparam int ST_ENABLED_BIT   = 2;
   localparam int ST_PIPELINED_BIT = 3;
   localparam int ST_HOLD_LSB      = 4;

   typedef enum logic [1:0] {
      LINE_INVALID,
      LINE_EXCLUSIVE,
      LINE_MODIFIED
   } line_state_e;

endpackage : l2_cache_mode_pkg

// >>> rtl/line_status_array.sv
// per-line valid, dirty and tag storage with single-cycle global invalidate
`timescale 1ns/1ns
module line_status_array
   import l2_cache_mode_pkg::*;
#(
   parameter int IDX_W = 4,
   parameter int TAG_W = 23
) (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // lookup
   input  wire logic [IDX_W-1:0] look_idx,
   input  wire logic [TAG_W-1:0] look_tag,
   output logic                  look_hit,
   // update
   input  wire logic             upd_en,
   input  wire logic [IDX_W-1:0] upd_idx,
   input  wire logic [TAG_W-1:0] upd_tag,
   input  wire line_state_e      upd_state,
   // invalidate and status
   input  wire logic             inv_all,
   output logic                  any_valid
);

   localparam int LINES = 1 << IDX_W;

   logic [LINES-1:0] valid_q;
   logic [LINES-1:0] dirty_q;
   logic [TAG_W-1:0] tag_q [LINES];

   // ----------------------------------------------------------------
   // storage, one process per line
   // ----------------------------------------------------------------
   for (genvar i = 0; i < LINES; i++) begin : g_line
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            valid_q[i] <= 1'b0;
            dirty_q[i] <= 1'b0;
            tag_q[i]   <= '0;
         end else if (inv_all) begin
            // invalidate wins over a same-cycle update: software owns the ordering
            valid_q[i] <= 1'b0;
            dirty_q[i] <= 1'b0;
         end else if (upd_en && upd_idx == IDX_W'(i)) begin
            valid_q[i] <= (upd_state != LINE_INVALID);
            dirty_q[i] <= (upd_state == LINE_MODIFIED);
            tag_q[i]   <= upd_tag;
         end
      end
   end

   assign look_hit  = valid_q[look_idx] && (tag_q[look_idx] == look_tag);
   assign any_valid = |valid_q;

endmodule : line_status_array

// >>> rtl/l2_cache_mode_control.sv
// l2 cache mode control: apb control register, allocation policy and ram-side controls
`timescale 1ns/1ns

// Contract
// - ram-type field value 10 selects pipelined register-register burst sram interface.
// - no burst fills; every ram access carries its own address.
// - data-only: instruction hits served, instruction misses bypass as inhibited.
// - data-only plus instruction-only locks cache: misses never allocate, write hits update.
// - writing global-invalidate clears every line status bit.
// - with sleep control set, low-power output follows nap or sleep mode.
// - write-through sends every cache write to the system bus too, except test-support pushes.
// - write-through marks written lines exclusive, never modified.
// - test support: l1 pushes go only to cache, valid; default bus and invalidate.
// - test support: no dcbz broadcast, no bus write for single-beat store misses.
// - output-hold field drives ram output hold; 00 is shortest.
// - enable bit takes effect from the next transaction, snooping included.
// - instruction-only: data hits served, data misses bypass as inhibited.
module l2_cache_mode_control
   import l2_cache_mode_pkg::*;
#(
   parameter int ADDR_W = 32,
   parameter int OFF_W  = 5,
   parameter int IDX_W  = 4
) (
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // apb slave
   input  wire logic [11:0]       paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // transaction request from the l1 side
   input  wire logic              txn_valid,
   input  wire logic [ADDR_W-1:0] txn_addr,
   input  wire logic              txn_instr,
   input  wire logic              txn_write,
   input  wire logic              txn_push,
   input  wire logic              txn_dcbz,
   input  wire logic              txn_single_beat,
   // power modes
   input  wire logic              nap_mode,
   input  wire logic              sleep_mode,
   // transaction decision
   output logic                   dec_valid,
   output logic                   dec_use_cache,
   output logic                   dec_inhibited,
   output logic                   dec_allocate,
   output logic                   dec_bus_read,
   output logic                   dec_bus_write,
   output logic                   dec_broadcast,
   output line_state_e            dec_line_state,
   // cache ram side
   output logic [ADDR_W-1:0]      ram_addr,
   output logic                   ram_addr_strobe,
   output logic                   ram_burst_adv,
   output logic                   ram_low_power_out,
   output logic                   ram_pipelined,
   output logic [1:0]             output_hold_sel,
   output logic                   snoop_enable
);

   localparam int TAG_W = ADDR_W - OFF_W - IDX_W;

   // ----------------------------------------------------------------
   // apb register file
   // ----------------------------------------------------------------
   logic [31:0] ctrl_q;
   logic [31:0] ctrl_d;
   logic [31:0] prdata_q;
   logic        acc;
   logic        setup;
   logic        hit_ctrl;
   logic        hit_status;
   logic        wr_ctrl;
   logic        inv_all;
   logic        any_valid;
   logic        en_eff_q;
   logic        low_power_q;
   logic [31:0] status_val;

   assign acc        = psel && penable;
   assign setup      = psel && !penable;
   assign hit_ctrl   = (paddr == CTRL_OFFSET);
   assign hit_status = (paddr == STATUS_OFFSET);
   assign wr_ctrl    = acc && pwrite && hit_ctrl;
   assign pready     = 1'b1;
   // status is read only, so a write to it is refused like an unmapped address
   assign pslverr    = acc && !(hit_ctrl || (hit_status && !pwrite));
   assign prdata     = prdata_q;

   always_comb begin
      ctrl_d = ctrl_q;
      for (int b = 0; b < 4; b++) begin
         if (pstrb[b]) begin
            ctrl_d[b*8 +: 8] = pwdata[b*8 +: 8] & CTRL_WR_MASK[b*8 +: 8];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_q <= ctrl_d;
      end
   end

   // invalidate acts on the write itself; the stored bit is only a record
   assign inv_all = wr_ctrl && pstrb[INV_BIT/8] && pwdata[INV_BIT];

   always_comb begin
      status_val                              = 32'h0000_0000;
      status_val[ST_LOW_POWER_BIT]            = low_power_q;
      status_val[ST_ANY_VALID_BIT]            = any_valid;
      status_val[ST_ENABLED_BIT]              = en_eff_q;
      status_val[ST_PIPELINED_BIT]            = ram_pipelined;
      status_val[ST_HOLD_LSB +: 2]            = output_hold_sel;
   end

   // read data is captured in the setup cycle; zero-wait access follows
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         prdata_q <= hit_ctrl ? ctrl_q : (hit_status ? status_val : 32'h0000_0000);
      end
   end

   // ----------------------------------------------------------------
   // field views
   // ----------------------------------------------------------------
   logic do_sel;
   logic io_sel;
   logic wt_sel;
   logic ts_sel;
   logic ctl_sel;

   assign do_sel  = ctrl_q[DO_BIT];
   assign io_sel  = ctrl_q[IO_BIT];
   assign wt_sel  = ctrl_q[WT_BIT];
   assign ts_sel  = ctrl_q[TS_BIT];
   assign ctl_sel = ctrl_q[CTL_BIT];

   // ----------------------------------------------------------------
   // effective enable, sampled at each transaction
   // ----------------------------------------------------------------
   logic en_now;

   assign en_now = txn_valid ? ctrl_q[EN_BIT] : en_eff_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_eff_q <= 1'b0;
      end else if (txn_valid) begin
         en_eff_q <= ctrl_q[EN_BIT];
      end
   end

   assign snoop_enable = en_eff_q;

   // ----------------------------------------------------------------
   // line status lookup
   // ----------------------------------------------------------------
   logic        look_hit;
   logic        upd_en;
   line_state_e upd_state;

   line_status_array #(
      .IDX_W (IDX_W),
      .TAG_W (TAG_W)
   ) u_lines (
      .pclk      (pclk),
      .presetn   (presetn),
      .look_idx  (txn_addr[OFF_W +: IDX_W]),
      .look_tag  (txn_addr[OFF_W+IDX_W +: TAG_W]),
      .look_hit  (look_hit),
      .upd_en    (upd_en),
      .upd_idx   (txn_addr[OFF_W +: IDX_W]),
      .upd_tag   (txn_addr[OFF_W+IDX_W +: TAG_W]),
      .upd_state (upd_state),
      .inv_all   (inv_all),
      .any_valid (any_valid)
   );

   // ----------------------------------------------------------------
   // allocation policy
   // ----------------------------------------------------------------
   logic        hit;
   logic        miss;
   logic        inhib;
   logic        d_use;
   logic        d_alloc;
   logic        d_rd;
   logic        d_wr;
   logic        d_bc;
   line_state_e d_state;
   line_state_e wr_state;

   assign hit      = en_now && look_hit;
   assign miss     = en_now && !look_hit;
   // both selects set means every miss is inhibited: the cache is locked
   assign inhib    = !en_now || (miss && ((txn_instr && do_sel) ||
                                          (!txn_instr && io_sel)));
   assign wr_state = wt_sel ? LINE_EXCLUSIVE : LINE_MODIFIED;

   always_comb begin
      d_use   = 1'b0;
      d_alloc = 1'b0;
      d_rd    = 1'b0;
      d_wr    = 1'b0;
      d_bc    = 1'b0;
      d_state = LINE_INVALID;
      upd_en  = 1'b0;
      if (txn_dcbz) begin
         d_bc = !ts_sel;
      end else if (txn_push) begin
         if (ts_sel && !inhib) begin
            // pushed data lands only in the cache and the line becomes valid
            d_use   = 1'b1;
            d_alloc = miss;
            d_state = wr_state;
            upd_en  = 1'b1;
         end else begin
            d_wr   = 1'b1;
            upd_en = hit;
         end
      end else if (txn_write) begin
         if (hit) begin
            d_use   = 1'b1;
            d_wr    = wt_sel;
            d_state = wr_state;
            upd_en  = 1'b1;
         end else if (inhib) begin
            d_wr = 1'b1;
         end else if (txn_single_beat) begin
            // single-beat misses never allocate
            d_wr = !ts_sel;
         end else begin
            d_use   = 1'b1;
            d_alloc = 1'b1;
            d_wr    = wt_sel;
            d_state = wr_state;
            upd_en  = 1'b1;
         end
      end else begin
         if (hit) begin
            d_use   = 1'b1;
            d_state = LINE_EXCLUSIVE;
         end else if (inhib) begin
            d_rd = 1'b1;
         end else begin
            d_use   = 1'b1;
            d_alloc = 1'b1;
            d_rd    = 1'b1;
            d_state = LINE_EXCLUSIVE;
            upd_en  = 1'b1;
         end
      end
      if (!txn_valid) begin
         upd_en = 1'b0;
      end
   end

   assign upd_state = d_state;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dec_valid      <= 1'b0;
         dec_use_cache  <= 1'b0;
         dec_inhibited  <= 1'b0;
         dec_allocate   <= 1'b0;
         dec_bus_read   <= 1'b0;
         dec_bus_write  <= 1'b0;
         dec_broadcast  <= 1'b0;
         dec_line_state <= LINE_INVALID;
      end else begin
         dec_valid      <= txn_valid;
         dec_use_cache  <= txn_valid && d_use;
         dec_inhibited  <= txn_valid && inhib && !txn_dcbz;
         dec_allocate   <= txn_valid && d_alloc;
         dec_bus_read   <= txn_valid && d_rd;
         dec_bus_write  <= txn_valid && d_wr;
         dec_broadcast  <= txn_valid && d_bc;
         dec_line_state <= txn_valid ? d_state : LINE_INVALID;
      end
   end

   // ----------------------------------------------------------------
   // cache ram side
   // ----------------------------------------------------------------
   // one strobe per access and no burst advance: costs address bandwidth, but
   // keeps the ram interface free of a burst counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ram_addr        <= '0;
         ram_addr_strobe <= 1'b0;
         ram_burst_adv   <= 1'b0;
      end else begin
         ram_addr_strobe <= txn_valid && d_use;
         ram_burst_adv   <= 1'b0;
         if (txn_valid) begin
            ram_addr <= txn_addr;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_power_q <= 1'b0;
      end else begin
         low_power_q <= ctl_sel && (nap_mode || sleep_mode);
      end
   end

   assign ram_low_power_out = low_power_q;
   assign ram_pipelined     = (ctrl_q[RAM_TYPE_LSB +: 2] == RAM_TYPE_PIPELINED);
   assign output_hold_sel   = ctrl_q[OH_LSB +: 2];

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_inv_clears;
      @(posedge pclk) disable iff (!presetn)
      inv_all |=> !any_valid;
   endproperty
   a_inv_clears: assert property (p_inv_clears)
      else $error("lines still valid after global invalidate");

   property p_lp_follows;
      @(posedge pclk) disable iff (!presetn)
      ctl_sel && (nap_mode || sleep_mode) |=> ram_low_power_out ##1
      (ram_low_power_out == $past(ctl_sel && (nap_mode || sleep_mode)));
   endproperty
   a_lp_follows: assert property (p_lp_follows)
      else $error("low-power output does not follow nap or sleep");

   property p_lp_off;
      @(posedge pclk) disable iff (!presetn)
      !(nap_mode || sleep_mode) |=> !ram_low_power_out;
   endproperty
   a_lp_off: assert property (p_lp_off)
      else $error("low-power output stays on outside nap and sleep");

   property p_wt_hit_write;
      @(posedge pclk) disable iff (!presetn)
      txn_valid && txn_write && !txn_push && !txn_dcbz && wt_sel && hit
      |=> dec_bus_write && dec_use_cache;
   endproperty
   a_wt_hit_write: assert property (p_wt_hit_write)
      else $error("write-through hit not sent to the bus");

   property p_wt_never_mod;
      @(posedge pclk) disable iff (!presetn)
      txn_valid && wt_sel |=> dec_line_state != LINE_MODIFIED;
   endproperty
   a_wt_never_mod: assert property (p_wt_never_mod)
      else $error("write-through produced a modified line");

   property p_instr_miss;
      @(posedge pclk) disable iff (!presetn)
      txn_valid && txn_instr && do_sel && !look_hit |=> dec_inhibited && !dec_allocate;
   endproperty
   a_instr_miss: assert property (p_instr_miss)
      else $error("instruction miss allocated under data-only");

   property p_data_miss;
      @(posedge pclk) disable iff (!presetn)
      txn_valid && !txn_instr && !txn_dcbz && io_sel && !look_hit
      |=> dec_inhibited && !dec_allocate;
   endproperty
   a_data_miss: assert property (p_data_miss)
      else $error("data miss allocated under instruction-only");

   property p_locked;
      @(posedge pclk) disable iff (!presetn)
      txn_valid && do_sel && io_sel && !look_hit |=> !dec_allocate;
   endproperty
   a_locked: assert property (p_locked)
      else $error("locked cache allocated a line");

   property p_push_ts;
      @(posedge pclk) disable iff (!presetn)
      txn_valid && txn_push && !txn_dcbz && ts_sel && hit |=> !dec_bus_write && dec_use_cache;
   endproperty
   a_push_ts: assert property (p_push_ts)
      else $error("test-support push reached the bus");

   property p_dcbz_ts;
      @(posedge pclk) disable iff (!presetn)
      txn_valid && txn_dcbz && ts_sel |=> !dec_broadcast;
   endproperty
   a_dcbz_ts: assert property (p_dcbz_ts)
      else $error("dcbz broadcast under test support");

   property p_enable_next;
      @(posedge pclk) disable iff (!presetn)
      txn_valid |=> snoop_enable == $past(ctrl_q[EN_BIT]);
   endproperty
   a_enable_next: assert property (p_enable_next)
      else $error("enable not taken at the transaction");

   property p_reg_write;
      @(posedge pclk) disable iff (!presetn)
      wr_ctrl && pstrb == 4'hf |=> ctrl_q == ($past(pwdata) & CTRL_WR_MASK);
   endproperty
   a_reg_write: assert property (p_reg_write)
      else $error("control register lost its written value");

   property p_addr_each;
      @(posedge pclk) disable iff (!presetn)
      txn_valid |=> ram_addr == $past(txn_addr) && !ram_burst_adv;
   endproperty
   a_addr_each: assert property (p_addr_each)
      else $error("ram address not presented per access");

endmodule : l2_cache_mode_control

// >>> bench/sram_array_model.sv
// cache sram array model: watches the ram side for bursts and accesses in low power
`timescale 1ns/1ns
module sram_array_model (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // ram side
   input  wire logic ram_addr_strobe,
   input  wire logic ram_burst_adv,
   input  wire logic ram_low_power_out,
   // fault count
   output logic [7:0] faults
);
   // ----------------------------------------------------------------
   // fault watch
   // ----------------------------------------------------------------
   // the array never follows a burst; an access while asleep would be lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         faults <= 8'h00;
      else if (ram_burst_adv || (ram_addr_strobe && ram_low_power_out))
         faults <= faults + 8'h01;
   end
endmodule : sram_array_model

// >>> bench/tb_l2_cache_mode_control.sv
// self-checking testbench for the l2 cache mode control block
`timescale 1ns/1ns
module tb_l2_cache_mode_control
   import l2_cache_mode_pkg::*;
;
   // ----------------------------------------------------------------
   // signals and constants
   // ----------------------------------------------------------------
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, ram_addr, txn_addr;
   logic [3:0]  pstrb;
   logic        txn_valid, txn_instr, txn_write, txn_push, txn_dcbz, txn_single_beat;
   logic        nap_mode, sleep_mode, dec_valid, dec_use_cache, dec_inhibited;
   logic        dec_allocate, dec_bus_read, dec_bus_write, dec_broadcast;
   logic        ram_addr_strobe, ram_burst_adv, ram_low_power_out, ram_pipelined;
   logic        snoop_enable;
   logic [1:0]  output_hold_sel;
   line_state_e dec_line_state;
   logic [7:0]  faults;
   int          mismatches = 0;
   int          tests_run = 0;
   wire logic [7:0] dv = {dec_use_cache, dec_inhibited, dec_allocate, dec_bus_read,
                          dec_bus_write, dec_broadcast, dec_line_state};
   localparam logic [31:0] EN  = 32'h1 << EN_BIT;
   localparam logic [31:0] DOB = 32'h1 << DO_BIT;
   localparam logic [31:0] IOB = 32'h1 << IO_BIT;
   localparam logic [31:0] INV = 32'h1 << INV_BIT;
   localparam logic [31:0] CTL = 32'h1 << CTL_BIT;
   localparam logic [31:0] WT  = 32'h1 << WT_BIT;
   localparam logic [31:0] TS  = 32'h1 << TS_BIT;
   // qualifiers {instr, write, push, dcbz, single_beat}
   localparam logic [4:0] RD = 5'h00, IR = 5'h10, WRB = 5'h08, PU = 5'h04;
   localparam logic [4:0] DZ = 5'h02, SB = 5'h09;

`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
   $display("[ERR] %s exp %0h got %0h", nm, exp, got); end end

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   l2_cache_mode_control u_dut (
      .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
      .pready, .pslverr, .txn_valid, .txn_addr, .txn_instr, .txn_write, .txn_push,
      .txn_dcbz, .txn_single_beat, .nap_mode, .sleep_mode, .dec_valid, .dec_use_cache,
      .dec_inhibited, .dec_allocate, .dec_bus_read, .dec_bus_write, .dec_broadcast,
      .dec_line_state, .ram_addr, .ram_addr_strobe, .ram_burst_adv, .ram_low_power_out,
      .ram_pipelined, .output_hold_sel, .snoop_enable);

   sram_array_model u_ram (.pclk, .presetn, .ram_addr_strobe, .ram_burst_adv,
                           .ram_low_power_out, .faults);

   // ----------------------------------------------------------------
   // bus and transaction tasks
   // ----------------------------------------------------------------
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic ctrl(input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, CTRL_OFFSET, d, 4'hf, r, e);
   endtask : ctrl

   task automatic rdchk(input logic [11:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, 4'h0, r, e);
      `CHK("prdata", x, r)
      `CHK("pslverr", xe, e)
   endtask : rdchk

   // flush runs with the cache disabled, since invalidating a live cache is illegal
   task automatic flush;
      ctrl(32'h0);
      ctrl(INV);
   endtask : flush

   task automatic txn(input logic [31:0] a, input logic [4:0] q, input logic [7:0] x, m);
      @(posedge pclk);
      txn_valid <= 1'b1;
      txn_addr  <= a;
      {txn_instr, txn_write, txn_push, txn_dcbz, txn_single_beat} <= q;
      @(posedge pclk);
      txn_valid <= 1'b0;
      #1;
      `CHK("dec_valid", 1'b1, dec_valid)
      `CHK("ram_addr", a, ram_addr)
      `CHK("decision", x, dv & m)
   endtask : txn

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_regs;
      logic [31:0] r, v;
      logic        e;
      v = (32'(RAM_TYPE_PIPELINED) << RAM_TYPE_LSB) | (32'h3 << OH_LSB);
      rdchk(CTRL_OFFSET, CTRL_RESET, 1'b0);
      apb(1'b1, CTRL_OFFSET, 32'hffff_ffff, 4'b0100, r, e);
      rdchk(CTRL_OFFSET, 32'h00ff_0000, 1'b0);
      ctrl(v | 32'h0000_00ff);
      #1;
      `CHK("ram_pipelined", 1'b1, ram_pipelined)
      `CHK("output_hold_sel", 2'b11, output_hold_sel)
      rdchk(CTRL_OFFSET, v, 1'b0);
      ctrl(32'h1 << RAM_TYPE_LSB);
      #1;
      `CHK("ram_pipelined", 1'b0, ram_pipelined)
      `CHK("output_hold_sel", OH_LEAST, output_hold_sel)
      apb(1'b1, STATUS_OFFSET, 32'hffff_ffff, 4'hf, r, e);
      `CHK("status_wr_err", 1'b1, e)
      rdchk(12'h008, 32'h0, 1'b1);
      $display("t_regs done");
   endtask : t_regs

   task automatic t_alloc;
      txn(32'h1020, RD, 8'h40, 8'hc0);
      ctrl(EN);
      txn(32'h1020, RD, 8'hb1, 8'hff);
      `CHK("snoop_enable", 1'b1, snoop_enable)
      // status: one line valid and the cache enabled, nothing else set
      rdchk(STATUS_OFFSET, (32'h1 << ST_ANY_VALID_BIT) | (32'h1 << ST_ENABLED_BIT), 1'b0);
      txn(32'h1020, RD, 8'h80, 8'he0);
      txn(32'h1020, WRB, 8'h82, 8'hcb);
      flush;
      ctrl(WT); // write-through chosen before the enable
      ctrl(EN | WT);
      txn(32'h1020, RD, 8'h20, 8'h20);
      txn(32'h1020, WRB, 8'h89, 8'hcb);
      $display("t_alloc done");
   endtask : t_alloc

   task automatic t_lock;
      flush;
      ctrl(EN | DOB);
      txn(32'h2040, IR, 8'h40, 8'he0);
      txn(32'h2040, RD, 8'h20, 8'h20);
      txn(32'h2040, IR, 8'h80, 8'hc0);
      ctrl(EN | IOB);
      txn(32'h3060, RD, 8'h40, 8'he0);
      txn(32'h2040, RD, 8'h80, 8'hc0);
      ctrl(EN | DOB | IOB);
      txn(32'h4080, WRB, 8'h40, 8'he0);
      txn(32'h2040, WRB, 8'h82, 8'hc3);
      $display("t_lock done");
   endtask : t_lock

   task automatic t_ts;
      flush;
      ctrl(EN | TS);
      txn(32'h50a0, PU, 8'ha2, 8'heb);
      txn(32'h50a0, RD, 8'h80, 8'he0);
      txn(32'h60c0, DZ, 8'h00, 8'h04);
      txn(32'h9100, SB, 8'h00, 8'h28);
      ctrl(EN); // test support back to zero for normal use
      txn(32'h50a0, PU, 8'h08, 8'h08);
      txn(32'h50a0, RD, 8'h20, 8'h20);
      txn(32'h60c0, DZ, 8'h04, 8'h04);
      txn(32'h9100, SB, 8'h08, 8'h28);
      $display("t_ts done");
   endtask : t_ts

   task automatic t_power;
      ctrl(CTL);
      @(posedge pclk);
      nap_mode <= 1'b1; // no snoop is asked for during this nap
      #1 `CHK("lp_out", 1'b0, ram_low_power_out)
      @(posedge pclk);
      nap_mode   <= 1'b0;
      sleep_mode <= 1'b1;
      #1 `CHK("lp_out", 1'b1, ram_low_power_out)
      @(posedge pclk);
      sleep_mode <= 1'b0;
      #1 `CHK("lp_out", 1'b1, ram_low_power_out)
      @(posedge pclk);
      #1 `CHK("lp_out", 1'b0, ram_low_power_out)
      ctrl(32'h0);
      sleep_mode <= 1'b1;
      repeat (2) @(posedge pclk);
      #1 `CHK("lp_out", 1'b0, ram_low_power_out)
      @(posedge pclk);
      sleep_mode <= 1'b0;
      $display("t_power done");
   endtask : t_power

   task automatic end_sim;
      `CHK("model_faults", 8'h00, faults)
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_sim

   initial begin
      #400000;
      mismatches++;
      end_sim;
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {txn_valid, txn_addr, txn_instr, txn_write, txn_push, txn_dcbz} = '0;
      {txn_single_beat, nap_mode, sleep_mode} = 3'b000;
      presetn = 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_alloc;
      t_lock;
      t_ts;
      t_power;
      end_sim;
   end
endmodule : tb_l2_cache_mode_control
